// File: design/pwmt_channel.v
/*
 * one channel of a 16-bit pwm timer: count clock control, counter
 * control, counter value and the capture b / output b control field.
 * assumes a single-cycle register port on core_clk; slow oscillator and
 * capture pin arrive asynchronously and are synchronised here.
 */
// Chosen here: the strobed register port.
// Summary of operation
// - divide count clock by 4-bit selected ratio
// - half clock mode enable at bit 6
// - buffer enable d3, one-shot/repeat select d2
// - counter value readable, read-only, resets zero
// - capture b edge select at bits 15-14
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_channel #(
    parameter ADDR_W = 16,
    parameter DATA_W = 16
) (
    input  wire              core_clk,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [DATA_W-1:0] reg_rdata_q,
    input  wire              slow_oscillator,
    input  wire              capture_b_in,
    output reg               capture_b_pulse_q,
    output reg  [15:0]       capture_b_value_q,
    output reg               timer_out_b_q,
    output reg               counter_wrap_q
);

// ****************************************************************
// register state
// ****************************************************************
reg  [3:0]  clock_divide_select_q;
reg  [1:0]  clock_source_select_q;
reg         count_clock_enable_q;
reg         half_clock_mode_q;
reg         compare_buffer_enable_q;
reg         oneshot_repeat_select_q;
reg         run_q;
reg  [15:0] counter_value_q;
reg  [1:0]  capture_b_edge_select_q;
reg  [1:0]  output_b_mode_select_q;
reg         half_phase_q;

// ****************************************************************
// reset words
// ****************************************************************
// fields are sliced from the header words so one edit moves both
localparam [7:0]  CLK_RST = `PWMT_CLOCK_CTRL_RESET;
localparam [15:0] CTL_RST = `PWMT_COUNTER_CTRL_RESET;

// ****************************************************************
// access decode
// ****************************************************************
wire wr_clk;
wire wr_ctl;
wire wr_ccc;

assign wr_clk = reg_wr & (reg_addr == `PWMT_OFS_CLOCK_CTRL);
assign wr_ctl = reg_wr & (reg_addr == `PWMT_OFS_COUNTER_CTRL);
assign wr_ccc = reg_wr & (reg_addr == `PWMT_OFS_CCAP_CTRL);

// ****************************************************************
// input synchronisers
// ****************************************************************
// only the second stage and the edge history are looked at
reg slow_s1_q;
reg slow_s2_q;
reg slow_s3_q;
reg cap_s1_q;
reg cap_s2_q;
reg cap_s3_q;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slow_s1_q <= 1'b0;
        slow_s2_q <= 1'b0;
        slow_s3_q <= 1'b0;
        cap_s1_q  <= 1'b0;
        cap_s2_q  <= 1'b0;
        cap_s3_q  <= 1'b0;
    end else begin
        slow_s1_q <= slow_oscillator;
        slow_s2_q <= slow_s1_q;
        slow_s3_q <= slow_s2_q;
        cap_s1_q  <= capture_b_in;
        cap_s2_q  <= cap_s1_q;
        cap_s3_q  <= cap_s2_q;
    end
end

wire slow_tick;
wire cap_rise;
wire cap_fall;

// slow source must run well below core_clk/2 to be seen at all
assign slow_tick = slow_s2_q & ~slow_s3_q;
assign cap_rise  = cap_s2_q & ~cap_s3_q;
assign cap_fall  = ~cap_s2_q & cap_s3_q;

// ****************************************************************
// count clock prescaler
// ****************************************************************
wire div_tick;

pwmt_prescaler #(
    .CNT_W (14)
) u_prescaler (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .enable    (count_clock_enable_q),
    .src_sel   (clock_source_select_q),
    .div_sel   (clock_divide_select_q),
    .slow_tick (slow_tick),
    .tick_q    (div_tick)
);

// ****************************************************************
// clock control register
// ****************************************************************
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        clock_divide_select_q <= CLK_RST[`PWMT_CLK_DIV_MSB:`PWMT_CLK_DIV_LSB];
        clock_source_select_q <= CLK_RST[`PWMT_CLK_SRC_MSB:`PWMT_CLK_SRC_LSB];
        count_clock_enable_q  <= CLK_RST[`PWMT_CLK_EN_BIT];
    end else if (wr_clk) begin
        clock_divide_select_q <=
            reg_wdata[`PWMT_CLK_DIV_MSB:`PWMT_CLK_DIV_LSB];
        clock_source_select_q <=
            reg_wdata[`PWMT_CLK_SRC_MSB:`PWMT_CLK_SRC_LSB];
        count_clock_enable_q  <= reg_wdata[`PWMT_CLK_EN_BIT];
    end
end

// ****************************************************************
// counter control register
// ****************************************************************
wire advance;
wire at_max;
wire oneshot_end;
wire creset;

// half clock mode takes every second divided pulse
assign advance     = run_q & count_clock_enable_q & div_tick &
                     (~half_clock_mode_q | half_phase_q);
assign at_max      = (counter_value_q == `PWMT_COUNTER_MAX);
assign oneshot_end = advance & at_max & oneshot_repeat_select_q;
assign creset      = wr_ctl & reg_wdata[`PWMT_CTL_CRESET_BIT];

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        half_clock_mode_q       <= CTL_RST[`PWMT_CTL_HCM_BIT];
        compare_buffer_enable_q <= CTL_RST[`PWMT_CTL_CBUF_BIT];
        oneshot_repeat_select_q <= CTL_RST[`PWMT_CTL_ONESHOT_BIT];
        run_q                   <= CTL_RST[`PWMT_CTL_RUN_BIT];
    end else begin
        if (wr_ctl) begin
            half_clock_mode_q       <=
                reg_wdata[`PWMT_CTL_HCM_BIT];
            compare_buffer_enable_q <=
                reg_wdata[`PWMT_CTL_CBUF_BIT];
            oneshot_repeat_select_q <=
                reg_wdata[`PWMT_CTL_ONESHOT_BIT];
        end
        // a software write outranks the one-shot stop
        if (wr_ctl) begin
            run_q <= reg_wdata[`PWMT_CTL_RUN_BIT];
        end else if (oneshot_end) begin
            run_q <= 1'b0;
        end
    end
end

// ****************************************************************
// counter
// ****************************************************************
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        counter_value_q <= `PWMT_COUNTER_RESET;
        half_phase_q    <= 1'b0;
    end else begin
        if (creset) begin
            counter_value_q <= `PWMT_COUNTER_RESET;
        end else if (advance) begin
            counter_value_q <= counter_value_q + 16'h0001;
        end
        if (creset | ~half_clock_mode_q) begin
            half_phase_q <= 1'b0;
        end else if (run_q & count_clock_enable_q & div_tick) begin
            half_phase_q <= ~half_phase_q;
        end
    end
end

// ****************************************************************
// compare/capture control register
// ****************************************************************
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        capture_b_edge_select_q <= `PWMT_TRG_NONE;
        output_b_mode_select_q  <= `PWMT_OUTB_OFF;
    end else if (wr_ccc) begin
        capture_b_edge_select_q <=
            reg_wdata[`PWMT_CCB_TRG_MSB:`PWMT_CCB_TRG_LSB];
        output_b_mode_select_q  <=
            reg_wdata[`PWMT_OUTB_MD_MSB:`PWMT_OUTB_MD_LSB];
    end
end

// ****************************************************************
// capture b and timer output b
// ****************************************************************
reg cap_hit;

always @* begin
    cap_hit = 1'b0;
    case (capture_b_edge_select_q)
        `PWMT_TRG_NONE: cap_hit = 1'b0;
        `PWMT_TRG_RISE: cap_hit = cap_rise;
        `PWMT_TRG_FALL: cap_hit = cap_fall;
        `PWMT_TRG_BOTH: cap_hit = cap_rise | cap_fall;
        default:        cap_hit = 1'b0;
    endcase
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        capture_b_pulse_q <= 1'b0;
        capture_b_value_q <= `PWMT_COUNTER_RESET;
        timer_out_b_q     <= 1'b0;
        counter_wrap_q    <= 1'b0;
    end else begin
        capture_b_pulse_q <= cap_hit;
        if (cap_hit) begin
            capture_b_value_q <= counter_value_q;
        end
        counter_wrap_q <= advance & at_max;
        // compare data live outside; the wrap stands in as the toggle
        if (output_b_mode_select_q == `PWMT_OUTB_OFF) begin
            timer_out_b_q <= 1'b0;
        end else if (advance & at_max) begin
            timer_out_b_q <= ~timer_out_b_q;
        end
    end
end

// ****************************************************************
// read back
// ****************************************************************
reg [DATA_W-1:0] rdata_d;

always @* begin
    rdata_d = {DATA_W{1'b0}};
    case (reg_addr)
        `PWMT_OFS_CLOCK_CTRL: begin
            rdata_d[`PWMT_CLK_DIV_MSB:`PWMT_CLK_DIV_LSB] =
                clock_divide_select_q;
            rdata_d[`PWMT_CLK_SRC_MSB:`PWMT_CLK_SRC_LSB] =
                clock_source_select_q;
            rdata_d[`PWMT_CLK_EN_BIT] = count_clock_enable_q;
        end
        `PWMT_OFS_COUNTER_CTRL: begin
            rdata_d[`PWMT_CTL_HCM_BIT]     = half_clock_mode_q;
            rdata_d[`PWMT_CTL_CBUF_BIT]    = compare_buffer_enable_q;
            rdata_d[`PWMT_CTL_ONESHOT_BIT] = oneshot_repeat_select_q;
            rdata_d[`PWMT_CTL_RUN_BIT]     = run_q;
        end
        `PWMT_OFS_COUNTER_VALUE: begin
            rdata_d = counter_value_q;
        end
        `PWMT_OFS_CCAP_CTRL: begin
            rdata_d[`PWMT_CCB_TRG_MSB:`PWMT_CCB_TRG_LSB] =
                capture_b_edge_select_q;
            rdata_d[`PWMT_OUTB_MD_MSB:`PWMT_OUTB_MD_LSB] =
                output_b_mode_select_q;
        end
        default: begin
            rdata_d = {DATA_W{1'b0}};
        end
    endcase
end

// rdata holds zero outside the cycle after a read
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_q <= {DATA_W{1'b0}};
    end else if (reg_rd) begin
        reg_rdata_q <= rdata_d;
    end else begin
        reg_rdata_q <= {DATA_W{1'b0}};
    end
end

endmodule
`default_nettype wire

// File: design/pwmt_regs.vh
/*
 * register map, field positions, reset values and fixed encodings of
 * one pwm timer channel.
 * assumes a 16-bit register port addressed at the printed byte offsets.
 */
`ifndef PWMT_REGS_VH
`define PWMT_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PWMT_OFS_CLOCK_CTRL     16'h5068
`define PWMT_OFS_COUNTER_CTRL   16'h5400
`define PWMT_OFS_COUNTER_VALUE  16'h5402
`define PWMT_OFS_CCAP_CTRL      16'h5404

// ****************************************************************
// count_clock_control fields
// ****************************************************************
`define PWMT_CLK_DIV_MSB        7
`define PWMT_CLK_DIV_LSB        4
`define PWMT_CLK_SRC_MSB        3
`define PWMT_CLK_SRC_LSB        2
`define PWMT_CLK_EN_BIT         0
`define PWMT_CLOCK_CTRL_RESET   8'h00

// ****************************************************************
// counter_control fields
// ****************************************************************
`define PWMT_CTL_HCM_BIT        6
`define PWMT_CTL_CBUF_BIT       3
`define PWMT_CTL_ONESHOT_BIT    2
`define PWMT_CTL_CRESET_BIT     1
`define PWMT_CTL_RUN_BIT        0
`define PWMT_COUNTER_CTRL_RESET 16'h0000
`define PWMT_COUNTER_RESET      16'h0000

// ****************************************************************
// compare_capture_control fields
// ****************************************************************
`define PWMT_CCB_TRG_MSB        15
`define PWMT_CCB_TRG_LSB        14
`define PWMT_OUTB_MD_MSB        13
`define PWMT_OUTB_MD_LSB        12
`define PWMT_CCAP_CTRL_RESET    16'h0000

// ****************************************************************
// encodings
// ****************************************************************
`define PWMT_SRC_FAST           2'h0
`define PWMT_SRC_SLOW           2'h1
`define PWMT_DIV_MAX_FAST       4'he
`define PWMT_DIV_MAX_SLOW       4'h8
`define PWMT_TRG_NONE           2'h0
`define PWMT_TRG_RISE           2'h1
`define PWMT_TRG_FALL           2'h2
`define PWMT_TRG_BOTH           2'h3
`define PWMT_OUTB_OFF           2'h0
`define PWMT_COUNTER_MAX        16'hffff

`endif

// File: design/pwmt_prescaler.v
/*
 * count clock prescaler: picks a source tick and divides it by a
 * power of two from 1/1 to 1/16384.
 * assumes the slow source tick is already synchronised to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_prescaler #(
    parameter CNT_W = 14
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire             enable,
    input  wire [1:0]       src_sel,
    input  wire [3:0]       div_sel,
    input  wire             slow_tick,
    output reg              tick_q
);

// ****************************************************************
// ratio decode
// ****************************************************************
function [CNT_W-1:0] div_mask;
    input [3:0] d;
    integer i;
    begin
        div_mask = {CNT_W{1'b0}};
        for (i = 0; i < CNT_W; i = i + 1) begin
            if (i < d) begin
                div_mask[i] = 1'b1;
            end
        end
    end
endfunction

reg  [CNT_W-1:0] cnt_q;
wire             src_tick;
wire             div_ok;
wire [CNT_W-1:0] mask;

assign src_tick = (src_sel == `PWMT_SRC_FAST) ? 1'b1 :
                  (src_sel == `PWMT_SRC_SLOW) ? slow_tick : 1'b0;
// slow source stops above 1/256, undefined ratios give no ticks
assign div_ok   = (src_sel == `PWMT_SRC_FAST) ?
                      (div_sel <= `PWMT_DIV_MAX_FAST) :
                  (src_sel == `PWMT_SRC_SLOW) ?
                      (div_sel <= `PWMT_DIV_MAX_SLOW) : 1'b0;
assign mask     = div_mask(div_sel);

// ****************************************************************
// divider
// ****************************************************************
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_q  <= {CNT_W{1'b0}};
        tick_q <= 1'b0;
    end else begin
        if (!enable) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (src_tick) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        tick_q <= enable & src_tick & div_ok &
                  ((cnt_q & mask) == mask);
    end
end

endmodule
`default_nettype wire

// File: tb/pwmt_channel_monitor.sv
/*
 * checker for one pwm timer channel: register read-back shape, pulse
 * widths and pin behaviour against the capture and output b fields.
 * assumes it is bound to pwmt_channel and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_channel_monitor #(
    parameter ADDR_W = 16,
    parameter DATA_W = 16
) (
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_q,
    input wire logic              slow_oscillator,
    input wire logic              capture_b_in,
    input wire logic              capture_b_pulse_q,
    input wire logic [15:0]       capture_b_value_q,
    input wire logic              timer_out_b_q,
    input wire logic              counter_wrap_q
);
    // ****************************************************************
    // shadow of the capture/output field and idle counters
    // ****************************************************************
    logic [3:0] ccap_q;
    logic [3:0] trg_idle_q;
    logic [3:0] outb_idle_q;
    // saturating counters give pipelined pulses time to drain
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ccap_q      <= 4'h0;
            trg_idle_q  <= 4'h0;
            outb_idle_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `PWMT_OFS_CCAP_CTRL) begin
                ccap_q <= reg_wdata[15:12];
            end
            trg_idle_q  <= (ccap_q[3:2] != 2'h0) ? 4'h0 :
                           trg_idle_q + {3'h0, trg_idle_q != 4'hf};
            outb_idle_q <= (ccap_q[1:0] != 2'h0) ? 4'h0 :
                           outb_idle_q + {3'h0, outb_idle_q != 4'hf};
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence

    AST_RD_IDLE:
        assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
        else $error("read data not zero outside a read");
    AST_RD_CLK:
        assert property (s_rd(`PWMT_OFS_CLOCK_CTRL) |=>
            (reg_rdata_q & 16'hff02) == 16'h0000)
        else $error("clock control reserved bits not zero");
    AST_RD_CTL:
        assert property (s_rd(`PWMT_OFS_COUNTER_CTRL) |=>
            (reg_rdata_q & 16'hffb2) == 16'h0000)
        else $error("counter control reserved or reset bit not zero");
    AST_RD_CCAP:
        assert property (s_rd(`PWMT_OFS_CCAP_CTRL) |=>
            reg_rdata_q == {$past(ccap_q), 12'h000})
        else $error("capture control read back wrong");
    AST_RD_UNMAP:
        assert property (s_rd(16'h5406) |=> reg_rdata_q == 16'h0000)
        else $error("unmapped read not zero");
    AST_WRAP_PULSE:
        assert property (counter_wrap_q |=> !counter_wrap_q [*8])
        else $error("wrap pulse too long");
    AST_CAP_NONE:
        assert property (trg_idle_q == 4'hf |-> !capture_b_pulse_q)
        else $error("capture pulse with no trigger selected");
    AST_CAP_VAL:
        assert property ($changed(capture_b_value_q) |->
            capture_b_pulse_q || $past(capture_b_pulse_q))
        else $error("capture value changed without capture");
    AST_OUTB_OFF:
        assert property (outb_idle_q == 4'hf |-> !timer_out_b_q)
        else $error("output b high while mode off");
    AST_OUTB_WRAP:
        assert property ($rose(timer_out_b_q) |->
            counter_wrap_q || $past(counter_wrap_q))
        else $error("output b rose without wrap");
endmodule

bind pwmt_channel pwmt_channel_monitor #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
) pwmt_channel_monitor_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .slow_oscillator(slow_oscillator),
    .capture_b_in(capture_b_in),
    .capture_b_pulse_q(capture_b_pulse_q),
    .capture_b_value_q(capture_b_value_q),
    .timer_out_b_q(timer_out_b_q),
    .counter_wrap_q(counter_wrap_q)
);
`default_nettype wire

// File: tb/pwmt_channel_test.sv
/*
 * self-checking bench for one pwm timer channel: reset values, access
 * kinds, count rates per source and ratio, capture edges, one-shot.
 * assumes pwmt_channel with its register port on a 200 MHz core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_channel_test;
    localparam logic [15:0] ofs_clk = `PWMT_OFS_CLOCK_CTRL;
    localparam logic [15:0] ofs_ctl = `PWMT_OFS_COUNTER_CTRL;
    localparam logic [15:0] ofs_val = `PWMT_OFS_COUNTER_VALUE;
    localparam logic [15:0] ofs_cc  = `PWMT_OFS_CCAP_CTRL;
    logic        core_clk, rst_n, reg_wr, reg_rd;
    logic        slow_oscillator, capture_b_in;
    logic [15:0] reg_addr, reg_wdata, reg_rdata_q, capture_b_value_q;
    logic        capture_b_pulse_q, timer_out_b_q, counter_wrap_q;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cap_n = 0;

    pwmt_channel pwmt_channel_inst (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .slow_oscillator(slow_oscillator),
        .capture_b_in(capture_b_in),
        .capture_b_pulse_q(capture_b_pulse_q),
        .capture_b_value_q(capture_b_value_q),
        .timer_out_b_q(timer_out_b_q), .counter_wrap_q(counter_wrap_q));

    // ****************************************************************
    // clock, slow source (8 cycle period), pulse counter
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        slow_oscillator = 1'b0;
        forever begin
            repeat (4) @(posedge core_clk);
            slow_oscillator <= ~slow_oscillator;
        end
    end
    always @(posedge core_clk) begin
        if (capture_b_pulse_q === 1'b1) cap_n <= cap_n + 1;
    end

    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        logic [15:0] v;
        rd(ofs_clk, v);
        chk("clock ctrl reset", 16'h0000, v);
        rd(ofs_ctl, v);
        chk("counter ctrl reset", 16'h0000, v);
        rd(ofs_val, v);
        chk("counter reset", 16'h0000, v);
        rd(ofs_cc, v);
        chk("capture ctrl reset", 16'h0000, v);
        rd(16'h5406, v);
        chk("unmapped", 16'h0000, v);
    endtask
    // reserved bits and the write-only reset bit must read 0
    task t_access;
        logic [15:0] v;
        wr(ofs_clk, 16'h00ff);
        rd(ofs_clk, v);
        chk("clock ctrl", 16'h00fd, v);
        wr(ofs_ctl, 16'hfffe);
        rd(ofs_ctl, v);
        chk("counter ctrl", 16'h004c, v);
        wr(ofs_val, 16'h1234);
        rd(ofs_val, v);
        chk("counter read only", 16'h0000, v);
        wr(ofs_cc, 16'hffff);
        rd(ofs_cc, v);
        chk("capture ctrl", 16'hf000, v);
        wr(ofs_clk, 16'h0000);
        wr(ofs_ctl, 16'h0000);
        wr(ofs_cc, 16'h0000);
    endtask
    // window is a whole number of count periods, so phase drops out
    task t_rate(input logic [1:0] s, input logic [3:0] d, input logic h,
                input int m, input logic [15:0] e);
        logic [15:0] v1, v2;
        wr(ofs_clk, {8'h00, d, s, 2'b01});
        wr(ofs_ctl, {9'h000, h, 6'h01});
        repeat (40) @(posedge core_clk);
        rd(ofs_val, v1);
        repeat (m - 2) @(posedge core_clk);
        rd(ofs_val, v2);
        chk("count delta", e, v2 - v1);
        wr(ofs_ctl, 16'h0002);
        rd(ofs_val, v1);
        chk("counter clear", 16'h0000, v1);
        wr(ofs_clk, 16'h0000);
    endtask
    // run two count cycles then stop, so a capture latches 2
    task t_cap;
        int c0;
        wr(ofs_clk, 16'h0001);
        wr(ofs_ctl, 16'h0001);
        wr(ofs_ctl, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(ofs_cc, {i[1:0], 14'h0000});
            repeat (10) @(posedge core_clk);
            c0 = cap_n;
            capture_b_in <= 1'b1;
            repeat (10) @(posedge core_clk);
            capture_b_in <= 1'b0;
            repeat (10) @(posedge core_clk);
            chk("capture pulses", (i == 0) ? 16'h0 : (i == 3) ? 16'h2 : 16'h1,
                16'(cap_n - c0));
            chk("capture value", (i == 0) ? 16'h0000 : 16'h0002,
                capture_b_value_q);
        end
        wr(ofs_cc, 16'h0000);
    endtask
    task t_oneshot;
        int n;
        logic [15:0] v;
        wr(ofs_cc, 16'h1000);
        wr(ofs_clk, 16'h0001);
        wr(ofs_ctl, 16'h0002);
        wr(ofs_ctl, 16'h0005);
        n = 0;
        while (counter_wrap_q !== 1'b1 && n < 70000) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("wrap seen", 16'h0001, {15'h0, counter_wrap_q});
        repeat (4) @(posedge core_clk);
        chk("output b toggled", 16'h0001, {15'h0, timer_out_b_q});
        rd(ofs_val, v);
        chk("oneshot stopped", 16'h0000, v);
        rd(ofs_ctl, v);
        chk("run cleared", 16'h0004, v);
        wr(ofs_cc, 16'h0000);
        repeat (4) @(posedge core_clk);
        chk("output b off", 16'h0000, {15'h0, timer_out_b_q});
        wr(ofs_ctl, 16'h0000);
        wr(ofs_clk, 16'h0000);
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        capture_b_in = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_access;
        t_rate(2'h0, 4'h0, 1'b0, 64, 16'h0040);
        t_rate(2'h0, 4'h3, 1'b0, 64, 16'h0008);
        t_rate(2'h0, 4'he, 1'b0, 16384, 16'h0001);
        t_rate(2'h0, 4'h3, 1'b1, 64, 16'h0004);
        t_rate(2'h1, 4'h0, 1'b0, 64, 16'h0008);
        t_rate(2'h1, 4'h8, 1'b0, 4096, 16'h0002);
        t_rate(2'h1, 4'h9, 1'b0, 64, 16'h0000);
        t_cap;
        t_oneshot;
        summarize;
    end
    initial begin
        repeat (98000) @(posedge core_clk);
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire
